// ### src/rmc_regs.sv
/*
 Retimer misc control register bank: two byte registers at 09h and 0Ah with
 strap preload, strap write lockout, hot-plug power logic and staged lane
 settings. Assumes a synchronous byte register port from the serial-bus slave.
*/
`timescale 1ns/100ps
module rmc_regs (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // straps and pins
    input  wire logic        config_src_strap,
    input  wire logic        swap_polarity_strap,
    input  wire logic        output_enable_in,
    input  wire logic        sink_hotplug_in,
    input  wire logic        retimer_active,
    input  wire logic [11:0] lane_pending_in,
    // controls to the device
    output logic             lane_swap,
    output logic             lane_invert,
    output logic             device_powerdown,
    output logic      [1:0]  config_bus_rate_sel,
    output logic             eq_sink_placement,
    output logic             source_hotplug_out,
    output logic             adaptive_equalizer_sel,
    output logic             equalizer_on,
    output logic             aux_bridge_on,
    output logic      [1:0]  function_mode_sel,
    output logic      [11:0] lane_live_out,
    output logic             commit_lane_settings
);
    import rmc_pkg::*;

    // register state
    logic                  swap_reg;
    logic                  pol_reg;
    logic                  pd_reg;
    logic                  inh_reg;
    logic [1:0]            rate_reg;
    logic                  place_reg;
    logic                  relay_reg;
    logic                  adapt_reg;
    logic                  eqon_reg;
    logic                  aux_reg;
    logic [1:0]            mode_reg;
    logic                  commit_reg;
    logic                  strap_load_reg;
    logic [7:0]            rdata_reg;
    // output copies, retimed so every pin comes from a flip-flop
    logic                  swap_o_reg;
    logic                  pol_o_reg;
    logic                  pdn_o_reg;
    logic                  hp_o_reg;
    logic [RMC_LANE_W-1:0] live_val;

    // one sub-address compare, shared by write decode and read mux
    function automatic logic rmc_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // address decode and write qualification
    wire        hit_lane = rmc_hit(reg_addr, RMC_LANE_POWER_OFS);
    wire        hit_eq   = rmc_hit(reg_addr, RMC_EQ_MODE_OFS);
    wire        wr_lane  = reg_wr && hit_lane;
    wire        wr_eq    = reg_wr && hit_eq;
    wire        host_ok  = config_src_strap;
    wire        commit_w = wr_eq && reg_wdata[RMC_COMMIT_BIT];
    // quiet lanes: settings pass straight through without commit
    // a quiet link carries no traffic, so changing it mid-word cannot glitch it
    wire        quiet    = !output_enable_in || !sink_hotplug_in || pd_reg;
    wire        xfer     = commit_w || quiet;
    // pending word: lane fields from outside plus the two equalizer bits
    wire [RMC_LANE_W-1:0] pend_val = {2'b00, adapt_reg, eqon_reg, lane_pending_in};

    // read mux; reserved and commit bits return zero
    wire [7:0]  rd_lane  = {swap_reg, pol_reg, 2'b00, pd_reg, inh_reg, rate_reg};
    wire [7:0]  rd_eq    = {place_reg, relay_reg, adapt_reg, eqon_reg,
                            aux_reg, 1'b0, mode_reg};
    wire [7:0]  rd_next  = hit_lane ? rd_lane :
                           hit_eq   ? rd_eq   : 8'h00;

    // derived controls
    // hot-plug power-down uses the raw pin level; a bouncing plug is not filtered
    wire        pdn_next = pd_reg || (!inh_reg && !sink_hotplug_in);
    wire        pol_next = pol_reg && retimer_active;
    wire        hp_next  = !relay_reg && sink_hotplug_in;

    // strap capture one clock after reset release, then host ownership
    // the strap is sampled once, so later changes on the pin are ignored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_load_reg <= 1'b1;
        end else begin
            strap_load_reg <= 1'b0;
        end
    end

    // lane and power register 09h
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            swap_reg <= RMC_SWAP_RST;
            pol_reg  <= RMC_POL_RST;
            pd_reg   <= RMC_PD_RST;
            inh_reg  <= RMC_HP_INH_RST;
            rate_reg <= RMC_RATE_RST;
        end else if (strap_load_reg) begin
            swap_reg <= swap_polarity_strap;
            pol_reg  <= swap_polarity_strap;
        end else if (wr_lane) begin
            // power and rate fields ignore the strap lock
            if (host_ok) begin
                swap_reg <= reg_wdata[RMC_SWAP_BIT];
                pol_reg  <= reg_wdata[RMC_POL_BIT];
            end
            pd_reg   <= reg_wdata[RMC_PD_BIT];
            inh_reg  <= reg_wdata[RMC_HP_INH_BIT];
            rate_reg <= reg_wdata[RMC_RATE_LSB +: 2];
        end
    end

    // equalizer and mode register 0Ah
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            place_reg <= RMC_PLACE_RST;
            relay_reg <= RMC_RELAY_RST;
            adapt_reg <= RMC_ADAPT_RST;
            eqon_reg  <= RMC_EQON_RST;
            aux_reg   <= RMC_AUX_RST;
            mode_reg  <= RMC_MODE_RST;
        end else if (wr_eq) begin
            place_reg <= reg_wdata[RMC_PLACE_BIT];
            relay_reg <= reg_wdata[RMC_RELAY_BIT];
            if (host_ok) begin
                adapt_reg <= reg_wdata[RMC_ADAPT_BIT];
            end
            eqon_reg  <= reg_wdata[RMC_EQON_BIT];
            aux_reg   <= reg_wdata[RMC_AUX_BIT];
            mode_reg  <= reg_wdata[RMC_MODE_LSB +: 2];
        end
    end

    // commit pulse self-clears the next clock
    // the commit bit itself is never stored, so it always reads back zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            commit_reg <= 1'b0;
        end else begin
            commit_reg <= commit_w;
        end
    end

    // registered outputs
    // read data holds between strobes, so the host may take it late
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_reg  <= 8'h00;
            swap_o_reg <= 1'b0;
            pol_o_reg  <= 1'b0;
            pdn_o_reg  <= 1'b0;
            hp_o_reg   <= 1'b0;
        end else begin
            if (reg_rd) begin
                rdata_reg <= rd_next;
            end
            swap_o_reg <= swap_reg;
            pol_o_reg  <= pol_next;
            pdn_o_reg  <= pdn_next;
            hp_o_reg   <= hp_next;
        end
    end

    // staged lane settings; equalizer bits reach lanes only through it
    rmc_stage u_stage (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pend_val (pend_val),
        .xfer     (xfer),
        .live_val (live_val)
    );

    // rate, placement, bridge and mode are flip-flops already, no retiming
    assign reg_rdata              = rdata_reg;
    assign lane_swap              = swap_o_reg;
    assign lane_invert            = pol_o_reg;
    assign device_powerdown       = pdn_o_reg;
    assign config_bus_rate_sel    = rate_reg;
    assign eq_sink_placement      = place_reg;
    assign source_hotplug_out     = hp_o_reg;
    assign adaptive_equalizer_sel = live_val[13];
    assign equalizer_on           = live_val[12];
    assign aux_bridge_on          = aux_reg;
    assign function_mode_sel      = mode_reg;
    assign lane_live_out          = live_val[11:0];
    assign commit_lane_settings   = commit_reg;
endmodule // rmc_regs

// ### src/rmc_pkg.sv
/*
 Package for the retimer misc control register bank: offsets, field positions,
 reset values, mode encodings. Assumes a byte-wide register port with sub-address.
*/
package rmc_pkg;
    // register sub-addresses
    localparam logic [7:0] RMC_LANE_POWER_OFS = 8'h09;
    localparam logic [7:0] RMC_EQ_MODE_OFS    = 8'h0A;

    // lane_power_bus_rate_control fields
    localparam int RMC_SWAP_BIT     = 7;
    localparam int RMC_POL_BIT      = 6;
    localparam int RMC_PD_BIT       = 3;
    localparam int RMC_HP_INH_BIT   = 2;
    localparam int RMC_RATE_LSB     = 0;

    // equalizer_function_mode_control fields
    localparam int RMC_PLACE_BIT    = 7;
    localparam int RMC_RELAY_BIT    = 6;
    localparam int RMC_ADAPT_BIT    = 5;
    localparam int RMC_EQON_BIT     = 4;
    localparam int RMC_AUX_BIT      = 3;
    localparam int RMC_COMMIT_BIT   = 2;
    localparam int RMC_MODE_LSB     = 0;

    // reset values
    localparam logic       RMC_PD_RST     = 1'b0;
    localparam logic       RMC_HP_INH_RST = 1'b0;
    localparam logic [1:0] RMC_RATE_RST   = 2'b10;
    localparam logic       RMC_PLACE_RST  = 1'b0;
    localparam logic       RMC_RELAY_RST  = 1'b0;
    localparam logic       RMC_ADAPT_RST  = 1'b1;
    localparam logic       RMC_EQON_RST   = 1'b1;
    localparam logic       RMC_AUX_RST    = 1'b1;
    localparam logic       RMC_SWAP_RST   = 1'b0;
    localparam logic       RMC_POL_RST    = 1'b0;

    // bus rate codes
    typedef enum logic [1:0] {
        RMC_RATE_5K   = 2'b00,
        RMC_RATE_10K  = 2'b01,
        RMC_RATE_100K = 2'b10,
        RMC_RATE_400K = 2'b11
    } rmc_rate_e;

    // function mode codes
    typedef enum logic [1:0] {
        RMC_MODE_REDRIVER  = 2'b00,
        RMC_MODE_AUTO_1G   = 2'b01,
        RMC_MODE_AUTO_HIGH = 2'b10,
        RMC_MODE_RETIMER   = 2'b11
    } rmc_mode_e;
    localparam logic [1:0] RMC_MODE_RST = 2'b01;

    // width of the staged lane settings word
    localparam int RMC_LANE_W = 16;
    // live lane word after reset: equalizer bits start at their register reset values
    localparam logic [RMC_LANE_W-1:0] RMC_LIVE_RST =
        {2'b00, RMC_ADAPT_RST, RMC_EQON_RST, 12'h000};
endpackage : rmc_pkg

// ### src/rmc_stage.sv
/*
 Staging register for lane settings: takes pending values at its input and transfers them to
 the live copy on commit or while the lanes are quiet. Assumes one clock domain.
*/
`timescale 1ns/100ps
module rmc_stage (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // pending settings and transfer control
    input  wire logic [rmc_pkg::RMC_LANE_W-1:0] pend_val,
    input  wire logic                          xfer,
    // settings seen by the lanes
    output logic      [rmc_pkg::RMC_LANE_W-1:0] live_val
);
    import rmc_pkg::*;

    logic [RMC_LANE_W-1:0] live_reg;

    // live copy loads only on transfer; reset matches the register reset values
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            live_reg <= RMC_LIVE_RST;
        end else if (xfer) begin
            live_reg <= pend_val;
        end
    end

    assign live_val = live_reg;
endmodule // rmc_stage

// ### tb/rmc_regs_checker.sv
/*
 Port checker for the retimer misc control register bank.
 Assumes one sys_clk domain and the asynchronous active-high rst.
*/
`timescale 1ns/100ps
module rmc_regs_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register port and pins
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        config_src_strap,
    input wire logic        output_enable_in,
    input wire logic        sink_hotplug_in,
    input wire logic        retimer_active,
    // controls
    input wire logic        lane_swap,
    input wire logic        lane_invert,
    input wire logic        device_powerdown,
    input wire logic [1:0]  config_bus_rate_sel,
    input wire logic        eq_sink_placement,
    input wire logic        source_hotplug_out,
    input wire logic        aux_bridge_on,
    input wire logic [1:0]  function_mode_sel,
    input wire logic [11:0] lane_live_out,
    input wire logic        commit_lane_settings
);
    import rmc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // write decodes; quiet means settings may flow without a commit
    wire w09       = reg_wr && (reg_addr == RMC_LANE_POWER_OFS);
    wire w0a       = reg_wr && (reg_addr == RMC_EQ_MODE_OFS);
    wire commit_wr = w0a && reg_wdata[RMC_COMMIT_BIT];
    // mirror of the forced power-down bit; the powerdown pin lags it and mixes in hot-plug
    logic pd_shadow;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pd_shadow <= RMC_PD_RST;
        end else if (w09) begin
            pd_shadow <= reg_wdata[RMC_PD_BIT];
        end
    end
    wire quiet     = !output_enable_in || !sink_hotplug_in || pd_shadow;
    a_swap_write: assert property (
        w09 && config_src_strap |-> ##2 lane_swap == $past(reg_wdata[RMC_SWAP_BIT], 2))
        else $error("lane swap did not follow write");
    a_swap_locked: assert property (
        w09 && !config_src_strap |-> ##2 lane_swap == $past(lane_swap))
        else $error("lane swap changed while strap locked");
    a_invert_mode: assert property (
        !$past(retimer_active) |-> !lane_invert)
        else $error("polarity inverted outside retimer operation");
    a_pd_cause: assert property (
        w09 |-> ##2 device_powerdown == ($past(reg_wdata[RMC_PD_BIT], 2)
            || (!$past(reg_wdata[RMC_HP_INH_BIT], 2) && !$past(sink_hotplug_in))))
        else $error("power-down does not match its causes");
    a_rate_direct: assert property (
        w09 |=> config_bus_rate_sel == $past(reg_wdata[1:0]))
        else $error("bus rate code not taken");
    a_mode_fields: assert property (
        w0a |=> {eq_sink_placement, aux_bridge_on, function_mode_sel}
            == {$past(reg_wdata[7]), $past(reg_wdata[3]), $past(reg_wdata[1:0])})
        else $error("placement, bridge or mode not taken");
    a_relay_gate: assert property (
        w0a |-> ##2 source_hotplug_out
            == (!$past(reg_wdata[RMC_RELAY_BIT], 2) && $past(sink_hotplug_in)))
        else $error("hot-plug relay wrong");
    a_commit_pulse: assert property (
        commit_lane_settings == $past(commit_wr))
        else $error("commit pulse not one cycle after its write");
    a_live_hold: assert property (
        $changed(lane_live_out) |-> commit_lane_settings || $past(quiet))
        else $error("lane settings moved without commit");
    c_commit: cover property (commit_lane_settings);
    c_locked: cover property (w09 && !config_src_strap);
    c_powerdown: cover property (device_powerdown && sink_hotplug_in == 1'b0);
endmodule // rmc_regs_checker

// ### tb/rmc_host_model.sv
/*
 Serial-bus host stand-in: byte writes and reads on the register port.
 Assumes the bank samples its strobes on the rising sys_clk.
*/
`timescale 1ns/100ps
module rmc_host_model (
    // clock
    input  wire logic       sys_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // data flipped on release so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // read data is registered, so take it one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        q = reg_rdata;
    endtask
endmodule // rmc_host_model

// ### tb/tb_retimer_misc_control_regs.sv
/*
 Self-checking bench for the retimer misc control register bank.
 Assumes rmc_pkg, the design and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb_retimer_misc_control_regs;
    import rmc_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
    logic        config_src_strap = 1'b1, swap_polarity_strap = 1'b1;
    logic        output_enable_in = 1'b0, sink_hotplug_in = 1'b1, retimer_active = 1'b0;
    logic [11:0] lane_pending_in = 12'h123, lane_live_out;
    logic        lane_swap, lane_invert, device_powerdown, eq_sink_placement;
    logic        source_hotplug_out, adaptive_equalizer_sel, equalizer_on;
    logic        aux_bridge_on, commit_lane_settings;
    logic [1:0]  config_bus_rate_sel, function_mode_sel;
    int          num_errors = 0, cmp_count = 0;
    // rows of {address, write data, read-back}; mode toggles then 400k after inhibit
    logic [23:0] rows [12] = '{24'h09FECE, 24'h093000, 24'h0A8080, 24'h0A4949,
        24'h0A3232, 24'h0A1B1B, 24'h0AFFFB, 24'h090808, 24'h090505, 24'h090606,
        24'h090707, 24'h105A00};
    always #50 sys_clk = ~sys_clk;
    rmc_regs u_rmc_regs (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .config_src_strap, .swap_polarity_strap, .output_enable_in,
        .sink_hotplug_in, .retimer_active, .lane_pending_in, .lane_swap, .lane_invert,
        .device_powerdown, .config_bus_rate_sel, .eq_sink_placement, .source_hotplug_out,
        .adaptive_equalizer_sel, .equalizer_on, .aux_bridge_on, .function_mode_sel,
        .lane_live_out, .commit_lane_settings);
    rmc_host_model u_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: the whole sequence needs about a hundred cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        chk({7'h0, adaptive_equalizer_sel, equalizer_on, lane_swap,
            source_hotplug_out, config_bus_rate_sel, aux_bridge_on,
            function_mode_sel}, 16'h0195);
        rst <= 1'b0;
        u_host.rd(RMC_LANE_POWER_OFS, q);
        chk({8'h0, q}, 16'h00C2);
        u_host.rd(RMC_EQ_MODE_OFS, q);
        chk({8'h0, q}, 16'h0039);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            sink_hotplug_in <= i[0];
            retimer_active  <= i[1];
            u_host.wr(rows[i][23:16], rows[i][15:8]);
            u_host.rd(rows[i][23:16], q);
            chk({8'h0, q}, {8'h0, rows[i][7:0]});
        end
        $display("test table done");
        sink_hotplug_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({4'h0, lane_live_out}, 16'h0123);
        output_enable_in <= 1'b1;
        lane_pending_in  <= 12'hA5C;
        repeat (4) @(posedge sys_clk);
        chk({4'h0, lane_live_out}, 16'h0123);
        u_host.wr(RMC_EQ_MODE_OFS, 8'h04);
        repeat (2) @(posedge sys_clk);
        chk({2'b0, adaptive_equalizer_sel, equalizer_on, lane_live_out}, 16'h3A5C);
        u_host.rd(RMC_EQ_MODE_OFS, q);
        chk({8'h0, q}, 16'h0000);
        $display("test commit done");
        config_src_strap <= 1'b0;
        u_host.wr(RMC_LANE_POWER_OFS, 8'hC7);
        u_host.rd(RMC_LANE_POWER_OFS, q);
        chk({8'h0, q}, 16'h0007);
        u_host.wr(RMC_EQ_MODE_OFS, 8'h20);
        u_host.rd(RMC_EQ_MODE_OFS, q);
        chk({8'h0, q}, 16'h0000);
        $display("test strap lock done");
        config_src_strap <= 1'b1;
        retimer_active   <= 1'b1;
        sink_hotplug_in  <= 1'b0;
        u_host.wr(RMC_LANE_POWER_OFS, 8'h40);
        repeat (2) @(posedge sys_clk);
        chk({13'h0, lane_invert, device_powerdown, source_hotplug_out}, 16'h0006);
        retimer_active  <= 1'b0;
        sink_hotplug_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({13'h0, lane_invert, device_powerdown, source_hotplug_out}, 16'h0001);
        $display("test pins done");
        print_verdict();
    end
endmodule // tb_retimer_misc_control_regs

bind rmc_regs rmc_regs_checker u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .config_src_strap, .output_enable_in, .sink_hotplug_in, .retimer_active, .lane_swap,
    .lane_invert, .device_powerdown, .config_bus_rate_sel, .eq_sink_placement,
    .source_hotplug_out, .aux_bridge_on, .function_mode_sel, .lane_live_out,
    .commit_lane_settings);
